// ### idle_powerdown_control_cfg.svh
// Offsets, field positions, reset values and timing counts of the power control block
`ifndef IDLE_POWERDOWN_CONTROL_CFG_SVH
`define IDLE_POWERDOWN_CONTROL_CFG_SVH

`define PWR_CTRL_OFFSET   4'h0
`define PWR_STATUS_OFFSET 4'h4

`define BIT_IDLE_REQ  0
`define BIT_PD_REQ    1
`define BIT_USER_F0   2
`define BIT_USER_F1   3
`define BIT_BAUD_DBL  7

`define PWR_CTRL_RESET 8'h00
`define PWR_CTRL_WMASK 8'h8F

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// Reset hold: two machine cycles of 12 oscillator periods, one clk per period
`define RST_HOLD_PERIODS 24
`define RST_HOLD_CYCLES  (`RST_HOLD_PERIODS)

`endif

// ### idle_powerdown_control_pkg.sv
// Types shared by the power control block
package idle_powerdown_control_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_PDWAKE
  } pwr_state_t;

endpackage

// ### idle_powerdown_control.sv
// Idle and power-down sequencer with its power control register on AXI4-Lite
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "idle_powerdown_control_cfg.svh"

module idle_powerdown_control
  import idle_powerdown_control_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        resetPin,
  input  wire logic        instrDone,
  input  wire logic        irqTaken,
  input  wire logic        extIrqAEn,
  input  wire logic        extIrqBEn,
  input  wire logic        extIrqAN,
  input  wire logic        extIrqBN,
  output var  logic        coreReset,
  output var  logic        cpuClkEn,
  output var  logic        oscEnable,
  output var  logic        strobeHoldHigh,
  output var  logic        strobeHoldLow,
  output var  logic        port0Float,
  output var  logic        portHold,
  output var  logic        baudDoubler,
  output var  logic        wakeIrqA,
  output var  logic        wakeIrqB
);

  pwr_state_t  state_r;
  pwr_state_t  state_nxt;
  logic [7:0]  pwrCtrl_r;
  logic [3:0]  awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        wrPcon;
  logic [4:0]  rstCnt_r;
  logic        lowA_r;
  logic        lowB_r;
  logic        wakeA;
  logic        wakeB;
  logic        exitWake;

  // Register write happens once address and data are both held
  assign wrPcon = awHave_r && wHave_r && !bvalid && (awAddr_r == `PWR_CTRL_OFFSET) && wStrb_r[0];

  // Wake pins are judged on level alone, so no clock edge history is needed
  assign wakeA = extIrqAEn && !extIrqAN;
  assign wakeB = extIrqBEn && !extIrqBN;
  // Exit on the first release of a pin that was holding the wake
  assign exitWake = (lowA_r && extIrqAN) || (lowB_r && extIrqBN);

  // Reset pin filter; coreReset reloads registers only, no memory is ever cleared
  always_ff @(posedge clk)
  begin
    if (rst || !resetPin)
      rstCnt_r <= 5'h00;
    else if (rstCnt_r != 5'(`RST_HOLD_CYCLES))
      rstCnt_r <= rstCnt_r + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      coreReset <= 1'b1;
    else
      coreReset <= resetPin && (rstCnt_r == 5'(`RST_HOLD_CYCLES - 1)) ||
                   (coreReset && resetPin);
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (instrDone && pwrCtrl_r[`BIT_PD_REQ])
          state_nxt = ST_PDOWN;
        else if (instrDone && pwrCtrl_r[`BIT_IDLE_REQ] && !irqTaken)
          state_nxt = ST_IDLE;
      ST_IDLE:
        if (irqTaken)
          state_nxt = ST_RUN;
      ST_PDOWN:
        if (wakeA || wakeB)
          state_nxt = ST_PDWAKE;
      ST_PDWAKE:
        if (exitWake)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  // Reset from the filtered pin ends any mode
  always_ff @(posedge clk)
  begin
    if (rst || coreReset)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Which pins held the wake, to see the first release
  always_ff @(posedge clk)
  begin
    if (rst || coreReset || state_r == ST_RUN)
    begin
      lowA_r <= 1'b0;
      lowB_r <= 1'b0;
    end
    else if (state_r == ST_PDOWN || state_r == ST_PDWAKE)
    begin
      lowA_r <= (lowA_r || wakeA) && !exitWake;
      lowB_r <= (lowB_r || wakeB) && !exitWake;
    end
  end

  // Interrupt request to the interrupt controller on wake exit
  always_ff @(posedge clk)
  begin
    if (rst || coreReset)
    begin
      wakeIrqA <= 1'b0;
      wakeIrqB <= 1'b0;
    end
    else
    begin
      wakeIrqA <= state_r == ST_PDWAKE && exitWake && lowA_r;
      wakeIrqB <= state_r == ST_PDWAKE && exitWake && lowB_r;
    end
  end

  // Power control register; a software set wins over a hardware clear
  always_ff @(posedge clk)
  begin
    if (rst || coreReset)
      pwrCtrl_r <= `PWR_CTRL_RESET;
    else if (wrPcon)
      pwrCtrl_r <= wData_r[7:0] & `PWR_CTRL_WMASK;
    else if (irqTaken && state_r != ST_PDOWN && state_r != ST_PDWAKE)
      pwrCtrl_r[`BIT_IDLE_REQ] <= 1'b0;
    else if (state_r == ST_PDWAKE && exitWake)
    begin
      pwrCtrl_r[`BIT_IDLE_REQ] <= 1'b0;
      pwrCtrl_r[`BIT_PD_REQ] <= 1'b0;
    end
  end

  // Pin and clock controls follow the next state so they line up with it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpuClkEn       <= 1'b1;
      oscEnable      <= 1'b1;
      strobeHoldHigh <= 1'b0;
      strobeHoldLow  <= 1'b0;
      port0Float     <= 1'b0;
      portHold       <= 1'b0;
    end
    else
    begin
      cpuClkEn       <= coreReset || state_nxt == ST_RUN;
      oscEnable      <= coreReset || state_nxt != ST_PDOWN;
      strobeHoldHigh <= !coreReset && state_nxt == ST_IDLE;
      strobeHoldLow  <= !coreReset && state_nxt == ST_PDOWN;
      port0Float     <= !coreReset && state_nxt != ST_RUN;
      portHold       <= !coreReset && state_nxt != ST_RUN;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      baudDoubler <= 1'b0;
    else
      baudDoubler <= wrPcon ? wData_r[`BIT_BAUD_DBL] : !coreReset && pwrCtrl_r[`BIT_BAUD_DBL];
  end

  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHave_r <= 1'b0;
      awAddr_r <= 4'h0;
      awready  <= 1'b0;
    end
    else
    begin
      awready <= !awHave_r && !(awvalid && awready) && !bvalid;
      if (awvalid && awready)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      else if (bvalid && bready)
        awHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wHave_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      wready  <= 1'b0;
    end
    else
    begin
      wready <= !wHave_r && !(wvalid && wready) && !bvalid;
      if (wvalid && wready)
      begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      else if (bvalid && bready)
        wHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end
    else if (bvalid)
    begin
      if (bready)
        bvalid <= 1'b0;
    end
    else if (awHave_r && wHave_r)
    begin
      bvalid <= 1'b1;
      bresp  <= (awAddr_r == `PWR_CTRL_OFFSET || awAddr_r == `PWR_STATUS_OFFSET) ?
                `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // AXI4-Lite read: one cycle from address to data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OKAY;
        case (araddr)
          `PWR_CTRL_OFFSET:   rdata <= {24'h00_0000, pwrCtrl_r};
          `PWR_STATUS_OFFSET: rdata <= {28'h000_0000, lowB_r, lowA_r, state_r};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pinHeldLow;
    state_r == ST_PDOWN && (wakeA || wakeB);
  endsequence

  sequence restarted;
    state_r == ST_PDWAKE && oscEnable;
  endsequence

  idle_gate_a: assert property (state_r == ST_IDLE |-> !cpuClkEn && strobeHoldHigh && portHold)
    else $error("idle without clock gate or strobe hold");

  idle_irq_exit_a: assert property (state_r == ST_IDLE && irqTaken && !wrPcon && !coreReset
    |=> state_r == ST_RUN && !pwrCtrl_r[`BIT_IDLE_REQ] && cpuClkEn)
    else $error("interrupt did not end idle");

  idle_entry_a: assert property (state_r == ST_RUN && !instrDone |=> state_r == ST_RUN)
    else $error("mode entered before instruction completed");

  flags_stable_a: assert property (!wrPcon && !coreReset
    |=> $stable(pwrCtrl_r[`BIT_USER_F1:`BIT_USER_F0]))
    else $error("user flags changed by hardware");

  pd_pins_a: assert property (state_r == ST_PDOWN
    |-> !oscEnable && strobeHoldLow && port0Float && !strobeHoldHigh)
    else $error("power-down pin states wrong");

  no_wake_a: assert property (state_r == ST_PDOWN && !wakeA && !wakeB && !coreReset
    |=> state_r == ST_PDOWN)
    else $error("left power-down without enabled wake");

  wake_restart_a: assert property (pinHeldLow and !coreReset |=> restarted)
    else $error("oscillator not restarted on low wake pin");

  wake_exit_a: assert property (state_r == ST_PDWAKE && exitWake && !coreReset && !wrPcon
    |=> state_r == ST_RUN && (wakeIrqA || wakeIrqB) && !pwrCtrl_r[`BIT_PD_REQ]
        && !pwrCtrl_r[`BIT_IDLE_REQ])
    else $error("wake exit sequence wrong");

  rst_filter_a: assert property ($rose(coreReset) |-> $past(rstCnt_r) == 5'(`RST_HOLD_CYCLES - 1))
    else $error("reset recognised without full hold");

  baud_follow_a: assert property (wrPcon && !coreReset ##1 !coreReset
    |=> baudDoubler == $past(wData_r[`BIT_BAUD_DBL], 2))
    else $error("baud doubler does not follow register");

endmodule
`default_nettype wire

// ### cpu_side_model.sv
// CPU core, interrupt controller and external wake pin model
`timescale 1ns/100ps
`default_nettype none
module cpu_side_model
(
  input  wire logic cpuClkEn,
  input  wire logic irqReq,
  input  wire logic pinALow,
  input  wire logic pinBLow,
  output var  logic instrDone,
  output var  logic irqTaken,
  output var  logic extIrqAN,
  output var  logic extIrqBN
);
  // Core completes one instruction in every cycle that it is clocked
  assign instrDone = cpuClkEn;
  // Interrupt controller vectors whatever the bench requests
  assign irqTaken = irqReq;
  // Pins read high once released; held low as long as the bench asks
  assign extIrqAN = ~pinALow;
  assign extIrqBN = ~pinBLow;
endmodule
`default_nettype wire

// ### idle_powerdown_control_bench.sv
// Self-checking bench for the idle and power-down sequencer
`timescale 1ns/100ps
`default_nettype none
`include "idle_powerdown_control_cfg.svh"
module idle_powerdown_control_bench;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        resetPin = 1'h0, irqReq = 1'h0, pinALow = 1'h0, pinBLow = 1'h0;
  logic        extIrqAEn = 1'h0, extIrqBEn = 1'h0;
  logic        instrDone, irqTaken, extIrqAN, extIrqBN, coreReset, cpuClkEn, oscEnable;
  logic        strobeHoldHigh, strobeHoldLow, port0Float, portHold, baudDoubler;
  logic        wakeIrqA, wakeIrqB;
  logic [33:0] expQ[$];
  logic [33:0] seen;
  int          errTotal = 0, samplesChecked = 0, wakeCntA = 0, wakeCntB = 0;

  always #12.5 clk = ~clk;

  idle_powerdown_control DUT (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .resetPin, .instrDone, .irqTaken, .extIrqAEn, .extIrqBEn,
    .extIrqAN, .extIrqBN, .coreReset, .cpuClkEn, .oscEnable, .strobeHoldHigh,
    .strobeHoldLow, .port0Float, .portHold, .baudDoubler, .wakeIrqA, .wakeIrqB);

  cpu_side_model partner (.cpuClkEn, .irqReq, .pinALow, .pinBLow, .instrDone, .irqTaken,
    .extIrqAN, .extIrqBN);

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk);
    expQ.push_back({resp, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] exp);
    @(posedge clk);
    expQ.push_back(exp);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Response monitor: each answer is matched against the oldest note; an answer with no note queued is counted wrong
  always @(posedge clk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      seen = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      if (expQ.size() == 0)
        chk("bus response", ~seen, seen);
      else
        chk("bus response", expQ.pop_front(), seen);
    end
    if (wakeIrqA === 1'h1)
      wakeCntA++;
    if (wakeIrqB === 1'h1)
      wakeCntB++;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errTotal++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(77));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    rd(`PWR_CTRL_OFFSET, {`RESP_OKAY, 32'h0});
    rd(`PWR_STATUS_OFFSET, {`RESP_OKAY, 32'h0});
    chk("run clocks", 34'h3, {32'h0, cpuClkEn, oscEnable});
    $display("test reset done");
    repeat (3)
    begin
      v = $urandom & 32'h8C;
      wr(`PWR_CTRL_OFFSET, v, `RESP_OKAY);
      rd(`PWR_CTRL_OFFSET, {`RESP_OKAY, v});
      chk("baud doubler", {33'h0, v[7]}, {33'h0, baudDoubler});
    end
    wr(4'h8, 32'h1, `RESP_SLVERR);
    rd(4'hC, {`RESP_SLVERR, 32'h0});
    wr(`PWR_STATUS_OFFSET, 32'h3, `RESP_OKAY);
    rd(`PWR_STATUS_OFFSET, {`RESP_OKAY, 32'h0});
    $display("test register done");
    wr(`PWR_CTRL_OFFSET, v | 32'h1, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("idle outputs", 34'h7, {30'h0, cpuClkEn, strobeHoldHigh, portHold, oscEnable});
    rd(`PWR_STATUS_OFFSET, {`RESP_OKAY, 32'h1});
    irqReq <= 1'h1;
    @(posedge clk);
    irqReq <= 1'h0;
    repeat (3) @(posedge clk);
    chk("clock after wake", 34'h1, {33'h0, cpuClkEn});
    rd(`PWR_CTRL_OFFSET, {`RESP_OKAY, v});
    $display("test idle done");
    extIrqAEn <= 1'h1;
    extIrqBEn <= 1'h1;
    wr(`PWR_CTRL_OFFSET, v | 32'h3, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("powerdown outputs", 34'h3, {31'h0, oscEnable, strobeHoldLow, port0Float});
    irqReq <= 1'h1;
    pinALow <= 1'h1;
    pinBLow <= 1'h1;
    @(posedge clk);
    irqReq <= 1'h0;
    repeat (3) @(posedge clk);
    chk("oscillator restart", 34'h1, {33'h0, oscEnable});
    pinALow <= 1'h0;
    repeat (3) @(posedge clk);
    chk("wake pulse A", 34'h1, 34'(wakeCntA));
    chk("wake pulse B", 34'h1, 34'(wakeCntB));
    pinBLow <= 1'h0;
    rd(`PWR_CTRL_OFFSET, {`RESP_OKAY, v});
    rd(`PWR_STATUS_OFFSET, {`RESP_OKAY, 32'h0});
    $display("test wake done");
    extIrqBEn <= 1'h0;
    wr(`PWR_CTRL_OFFSET, v | 32'h2, `RESP_OKAY);
    repeat (2) @(posedge clk);
    pinBLow <= 1'h1;
    repeat (4) @(posedge clk);
    chk("disabled pin", 34'h0, {33'h0, oscEnable});
    resetPin <= 1'h1;
    pinBLow <= 1'h0;
    repeat (24) @(posedge clk);
    chk("short reset", 34'h0, {33'h0, coreReset});
    repeat (2) @(posedge clk);
    chk("reset exit", 34'h3, {32'h0, coreReset, oscEnable});
    resetPin <= 1'h0;
    repeat (2) @(posedge clk);
    rd(`PWR_CTRL_OFFSET, {`RESP_OKAY, 32'h0});
    $display("test reset pin done");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
